// >>> verilog/port_mux_pkg.sv
// Package: widths, reset values and carriers for the port override mux
package port_mux_pkg;
  localparam int PIN_COUNT = 8;
  localparam logic [7:0] PORT_RST = 8'h00;
  // Wishbone register byte offsets
  localparam logic [3:0] OFS_DIR = 4'h0;
  localparam logic [3:0] OFS_OUT = 4'h4;
  localparam logic [3:0] OFS_PULL = 4'h8;
  localparam logic [3:0] OFS_PIN = 4'hC;
  // Pin-change and analog control register offsets
  localparam logic [4:0] OFS_PCSRC = 5'h10;
  localparam logic [4:0] OFS_CTRL = 5'h14;
  localparam logic [4:0] OFS_ADIS = 5'h18;
  localparam int CTRL_PCGRP_BIT = 0;
  localparam int CMP_POS_PIN = 1;
  localparam int CMP_NEG_PIN = 2;

  // Override group from one peripheral for all pins of the port
  typedef struct packed {
    logic [7:0] pullupOverrideEn;
    logic [7:0] pullupOverrideVal;
    logic [7:0] dirOverrideEn;
    logic [7:0] dirOverrideVal;
    logic [7:0] valueOverrideEn;
    logic [7:0] valueOverrideVal;
    logic [7:0] toggleOverrideEn;
    logic [7:0] inputEnOverrideEn;
    logic [7:0] inputEnOverrideVal;
  } override_t;

  // Pad-facing controls per pin
  typedef struct packed {
    logic [7:0] pullupEn;
    logic [7:0] driveEn;
    logic [7:0] driveVal;
    logic [7:0] inputEn;
  } pad_ctrl_t;
endpackage

// >>> verilog/port_pin_override_mux.sv
// Port A override multiplexer with Wishbone port registers
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module port_pin_override_mux
  import port_mux_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire logic clk_sys, // 125 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [4:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire port_mux_pkg::override_t periphOvr, // Peripheral overrides
  input wire logic sleepClamp, // Deep sleep clamp, shared
  input wire logic [7:0] schmittOut, // Pad Schmitt outputs
  output port_mux_pkg::pad_ctrl_t padCtrl, // Pad controls
  output logic [7:0] rawPinInput, // Unsynchronised pin input
  output logic [7:0] analogChanEn, // Analog channel select hint
  output logic comparatorPosInput, // Comparator + pin input gate
  output logic comparatorNegInput // Comparator - pin input gate
);
  import port_mux_pkg::*;

  // Register selected by one byte address
  typedef enum logic [2:0] {
    SEL_DIR = 3'b000,
    SEL_OUT = 3'b001,
    SEL_PULL = 3'b010,
    SEL_PIN = 3'b011,
    SEL_PCSRC = 3'b100,
    SEL_CTRL = 3'b101,
    SEL_ADIS = 3'b110,
    SEL_NONE = 3'b111
  } reg_sel_t;

  // Byte-lane write helper, only lane 0 carries port bits
  function automatic logic [7:0] laneWrite(input logic [7:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    laneWrite = sel[0] ? dat[7:0] : old;
  endfunction

  // Address decode shared by the write and read paths
  function automatic reg_sel_t regDecode(input logic [4:0] adr);
    case (adr)
      {1'b0, OFS_DIR}: regDecode = SEL_DIR;
      {1'b0, OFS_OUT}: regDecode = SEL_OUT;
      {1'b0, OFS_PULL}: regDecode = SEL_PULL;
      {1'b0, OFS_PIN}: regDecode = SEL_PIN;
      OFS_PCSRC: regDecode = SEL_PCSRC;
      OFS_CTRL: regDecode = SEL_CTRL;
      OFS_ADIS: regDecode = SEL_ADIS;
      default: regDecode = SEL_NONE;
    endcase
  endfunction

  // Byte widened to the bus, upper lanes read as zero
  function automatic logic [31:0] busByte(input logic [7:0] val);
    busByte = {24'h000000, val};
  endfunction

  // Port register bits
  logic [7:0] dirReg, dirNext;
  logic [7:0] outReg, outNext;
  logic [7:0] pullReg, pullNext;

  // Pin-change and analog control bits
  logic [7:0] pcSrcReg, pcSrcNext;
  logic pcGrpReg, pcGrpNext;
  logic [7:0] adisReg, adisNext;

  // Pin input synchroniser stages
  logic [7:0] syncAReg, syncANext;
  logic [7:0] pinInReg, pinInNext;

  // Bus answer
  logic ackReg, ackNext;
  logic [31:0] rdReg, rdNext;

  // Pad-facing outputs
  pad_ctrl_t padReg, padNext;
  logic [7:0] rawReg, rawNext;
  logic [7:0] anReg, anNext;
  logic cmpPReg, cmpPNext;
  logic cmpNReg, cmpNNext;

  // Request decode and per-pin mux results
  logic wbReq;
  logic wbWrite;
  logic wbRead;
  reg_sel_t regSel;
  logic [7:0] pcTerm;
  wire logic [7:0] ovrInEn;
  wire logic [7:0] ovrInVal;
  wire logic [7:0] outEff;
  wire logic [7:0] pullupMux;
  wire logic [7:0] driveEnMux;
  wire logic [7:0] driveValMux;
  wire logic [7:0] inputEnMux;

  // A request is taken once; the registered ack
  // blocks a second take of the same cycle
  assign wbReq = wb_cyc_i && wb_stb_i && !ackReg;
  assign wbWrite = wbReq && wb_we_i;
  assign wbRead = wbReq && !wb_we_i;
  assign regSel = regDecode(wb_adr_i);

  // Pin-change term per pin, group enable shared
  assign pcTerm = pcSrcReg & {8{pcGrpReg}};

  // One override slice per pin
  for (genvar g = 0; g < PINS; g++) begin : gen_pin
    // Input enable override: peripheral, pin change or analog disable
    assign ovrInEn[g] = periphOvr.inputEnOverrideEn[g]
                        | pcTerm[g] | adisReg[g];
    // Peripheral value counts only under its own enable
    assign ovrInVal[g] = (periphOvr.inputEnOverrideEn[g]
                         & periphOvr.inputEnOverrideVal[g])
                         | pcTerm[g];
    // Toggle inverts the driven value, register bit untouched
    assign outEff[g] = outReg[g] ^ periphOvr.toggleOverrideEn[g];
    // Pull-up override or pull-up bit
    assign pullupMux[g] = periphOvr.pullupOverrideEn[g]
                          ? periphOvr.pullupOverrideVal[g]
                          : pullReg[g];
    // Direction override or direction bit
    assign driveEnMux[g] = periphOvr.dirOverrideEn[g]
                           ? periphOvr.dirOverrideVal[g]
                           : dirReg[g];
    // Value override or output value bit
    assign driveValMux[g] = periphOvr.valueOverrideEn[g]
                            ? periphOvr.valueOverrideVal[g]
                            : outEff[g];
    // Input enable override or sleep clamp, shared by all ports
    assign inputEnMux[g] = ovrInEn[g] ? ovrInVal[g]
                                      : !sleepClamp;
  end

  // Register file next state, strobes shared by all pins
  always_comb begin
    dirNext = dirReg;
    outNext = outReg;
    pullNext = pullReg;
    pcSrcNext = pcSrcReg;
    pcGrpNext = pcGrpReg;
    adisNext = adisReg;
    if (wbWrite) begin
      case (regSel)
        SEL_DIR: begin
          dirNext = laneWrite(dirReg, wb_dat_i, wb_sel_i);
        end
        SEL_OUT: begin
          outNext = laneWrite(outReg, wb_dat_i, wb_sel_i);
        end
        SEL_PULL: begin
          pullNext = laneWrite(pullReg, wb_dat_i, wb_sel_i);
        end
        SEL_PIN: begin
          if (wb_sel_i[0]) begin
            outNext = outReg ^ wb_dat_i[7:0];
          end
        end
        SEL_PCSRC: begin
          pcSrcNext = laneWrite(pcSrcReg, wb_dat_i, wb_sel_i);
        end
        SEL_CTRL: begin
          if (wb_sel_i[0]) begin
            pcGrpNext = wb_dat_i[CTRL_PCGRP_BIT];
          end
        end
        SEL_ADIS: begin
          adisNext = laneWrite(adisReg, wb_dat_i, wb_sel_i);
        end
        default: begin
          // Unmapped address, write dropped
        end
      endcase
    end
  end

  // Bus answer: one-cycle ack, read data only beside it
  always_comb begin
    ackNext = wbReq;
    rdNext = 32'h00000000;
    if (wbRead) begin
      case (regSel)
        SEL_DIR: begin
          rdNext = busByte(dirReg);
        end
        SEL_OUT: begin
          rdNext = busByte(outReg);
        end
        SEL_PULL: begin
          rdNext = busByte(pullReg);
        end
        SEL_PIN: begin
          rdNext = busByte(pinInReg);
        end
        SEL_PCSRC: begin
          rdNext = busByte(pcSrcReg);
        end
        SEL_CTRL: begin
          rdNext = {31'h00000000, pcGrpReg};
        end
        SEL_ADIS: begin
          rdNext = busByte(adisReg);
        end
        default: begin
          rdNext = 32'h00000000;
        end
      endcase
    end
  end

  // Pad controls and raw input next state
  always_comb begin
    padNext.pullupEn = pullupMux;
    padNext.driveEn = driveEnMux;
    padNext.driveVal = driveValMux;
    padNext.inputEn = inputEnMux;
    rawNext = schmittOut & inputEnMux;
  end

  // Port synchroniser; peripherals get the raw value instead
  // so their own synchronisers see no extra delay
  always_comb begin
    syncANext = rawNext;
    pinInNext = syncAReg;
  end

  // Analog channel hint and comparator input gates
  always_comb begin
    anNext = adisReg | ~dirReg;
    cmpPNext = !dirReg[CMP_POS_PIN] && !pullReg[CMP_POS_PIN];
    cmpNNext = !dirReg[CMP_NEG_PIN] && !pullReg[CMP_NEG_PIN];
  end

  // Port and pin-change registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dirReg <= PORT_RST;
      outReg <= PORT_RST;
      pullReg <= PORT_RST;
      pcSrcReg <= PORT_RST;
      pcGrpReg <= 1'b0;
      adisReg <= PORT_RST;
    end else begin
      dirReg <= dirNext;
      outReg <= outNext;
      pullReg <= pullNext;
      pcSrcReg <= pcSrcNext;
      pcGrpReg <= pcGrpNext;
      adisReg <= adisNext;
    end
  end

  // Bus answer registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ackReg <= 1'b0;
      rdReg <= 32'h00000000;
    end else begin
      ackReg <= ackNext;
      rdReg <= rdNext;
    end
  end

  // Pad registers; reset leaves pads undriven and inputs off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      padReg <= '0;
      rawReg <= PORT_RST;
    end else begin
      padReg <= padNext;
      rawReg <= rawNext;
    end
  end

  // Synchroniser registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncAReg <= PORT_RST;
      pinInReg <= PORT_RST;
    end else begin
      syncAReg <= syncANext;
      pinInReg <= pinInNext;
    end
  end

  // Analog and comparator registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      anReg <= PORT_RST;
      cmpPReg <= 1'b0;
      cmpNReg <= 1'b0;
    end else begin
      anReg <= anNext;
      cmpPReg <= cmpPNext;
      cmpNReg <= cmpNNext;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdReg;
  assign padCtrl = padReg;
  assign rawPinInput = rawReg;
  assign analogChanEn = anReg;
  assign comparatorPosInput = cmpPReg;
  assign comparatorNegInput = cmpNReg;
endmodule

// >>> sim/port_mux_assertions.sv
// Port-level checks for the port override mux
`timescale 1ns/1ps
module port_mux_assertions
  import port_mux_pkg::*;
#(parameter int PINS = PIN_COUNT) (
  input wire logic clk_sys, // Clock
  input wire logic rst_n, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Ack
  input wire port_mux_pkg::override_t periphOvr, // Overrides
  input wire logic [7:0] schmittOut, // Pads
  input wire port_mux_pkg::pad_ctrl_t padCtrl, // Pad controls
  input wire logic [7:0] rawPinInput // Raw input
);
  override_t o;
  pad_ctrl_t p;
  // Short aliases
  assign o = periphOvr;
  assign p = padCtrl;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_pullup_ovr: assert property (
    ((p.pullupEn ^ $past(o.pullupOverrideVal))
    & $past(o.pullupOverrideEn)) == 8'h00) else $error("pull-up override");
  a_dir_ovr: assert property (
    ((p.driveEn ^ $past(o.dirOverrideVal))
    & $past(o.dirOverrideEn)) == 8'h00) else $error("direction override");
  a_value_ovr: assert property (
    ((p.driveVal ^ $past(o.valueOverrideVal)) & p.driveEn
    & $past(o.valueOverrideEn) & ~$past(o.toggleOverrideEn)) == 8'h00)
    else $error("value override");
  a_input_ovr: assert property (
    (~p.inputEn & $past(o.inputEnOverrideEn)
    & $past(o.inputEnOverrideVal)) == 8'h00) else $error("input override");
  a_raw_input: assert property (
    rawPinInput == ($past(schmittOut) & p.inputEn)) else $error("raw input");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits");
  cover property (wb_ack_o);
  cover property (|o.pullupOverrideEn);
  cover property (|o.toggleOverrideEn && |p.driveEn);
endmodule

// >>> sim/periph_ovr_model.sv
// Peripheral side model driving the override group
`timescale 1ns/1ps
module periph_ovr_model (
  input wire logic [1:0] mode, // Override scene
  output port_mux_pkg::override_t periphOvr // Overrides
);
  import port_mux_pkg::*;
  // Levels made inside the owning peripheral
  always_comb begin
    case (mode)
      2'h1: periphOvr = {40'hFF0FF050FF, 8'h33, 24'h0};
      2'h2: periphOvr = {48'h0, 8'hFF, 16'h0};
      2'h3: periphOvr = {56'h0, 16'hFF0F};
      default: periphOvr = '0;
    endcase
  end
endmodule

// >>> sim/port_pin_override_mux_tb.sv
// Self-checking bench for the port override mux
`timescale 1ns/1ps
module port_pin_override_mux_tb;
  import port_mux_pkg::*;
  logic clk_sys = 1'h0, rst_n = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0;
  logic wb_we_i = 1'h0, sleepClamp = 1'h0, wb_ack_o, cmpPos, cmpNeg;
  logic [4:0] wb_adr_i = 5'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic [7:0] schmittOut = 8'h3C, rawPinInput, analogChanEn;
  logic [1:0] mode = 2'h0;
  logic [7:0] rawSyncA = 8'h00, rawSync = 8'h00;
  override_t periphOvr;
  pad_ctrl_t p;
  int fails = 0, cmpCount = 0;
  always #4 clk_sys = ~clk_sys;
  port_pin_override_mux #(.PINS(PIN_COUNT)) i_port_pin_override_mux (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .periphOvr(periphOvr), .sleepClamp(sleepClamp),
    .schmittOut(schmittOut), .padCtrl(p), .rawPinInput(rawPinInput),
    .analogChanEn(analogChanEn), .comparatorPosInput(cmpPos),
    .comparatorNegInput(cmpNeg));
  periph_ovr_model i_periph_ovr_model (.mode(mode), .periphOvr(periphOvr));
  // Peripheral-side synchroniser on the raw pin input
  always_ff @(posedge clk_sys) begin
    rawSyncA <= rawPinInput;
    rawSync <= rawSyncA;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One classic cycle; reads are compared with e
  task bus(input logic w, input logic [4:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i}
      <= {2'h3, w, 4'h1, a, 24'h0, e};
    do @(posedge clk_sys); while (wb_ack_o !== 1'h1);
    if (!w) chk(wb_dat_o, {24'h0, e});
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task close_out;
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    #20000;
    fails++;
    close_out;
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    settle;
    chk(p.inputEn, 8'hFF);
    chk(rawPinInput, 8'h3C);
    bus(1'h1, 5'h00, 8'h0F);
    bus(1'h1, 5'h04, 8'hA5);
    bus(1'h1, 5'h08, 8'h30);
    settle;
    chk(p.driveEn, 8'h0F);
    chk(p.driveVal & p.driveEn, 8'h05);
    chk(p.pullupEn, 8'h30);
    bus(1'h1, 5'h0C, 8'hFF);
    bus(1'h0, 5'h04, 8'h5A);
    @(posedge clk_sys) mode <= 2'h1;
    settle;
    chk(p.pullupEn, 8'h0F);
    chk(p.driveEn, 8'h5F);
    chk(p.driveVal & p.driveEn, 8'h13);
    @(posedge clk_sys) mode <= 2'h2;
    settle;
    chk(p.driveVal & p.driveEn, 8'h05);
    @(posedge clk_sys) {mode, sleepClamp} <= 3'h1;
    settle;
    chk(p.inputEn, 8'h00);
    bus(1'h1, 5'h10, 8'h03);
    bus(1'h1, 5'h14, 8'h01);
    settle;
    chk(p.inputEn, 8'h03);
    @(posedge clk_sys) mode <= 2'h3;
    settle;
    chk(p.inputEn, 8'h0F);
    @(posedge clk_sys) {mode, sleepClamp} <= 3'h0;
    bus(1'h1, 5'h18, 8'h04);
    settle;
    chk(p.inputEn, 8'hFB);
    chk(analogChanEn, 8'hF4);
    chk(rawPinInput, 8'h38);
    bus(1'h0, 5'h1C, 8'h00);
    chk({cmpPos, cmpNeg}, 32'h0);
    bus(1'h0, 5'h0C, 8'h38);
    chk(rawSync, 8'h38);
    bus(1'h1, 5'h00, 8'h09);
    settle;
    chk({cmpPos, cmpNeg}, 32'h3);
    close_out;
  end
endmodule
bind port_pin_override_mux port_mux_assertions #(.PINS(PINS))
  i_port_mux_assertions (
  .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .periphOvr(periphOvr), .schmittOut(schmittOut), .padCtrl(padCtrl),
  .rawPinInput(rawPinInput));
